//--- include/see_pkg.sv
// How it works
// - write control byte: code, selects, low bit
// - byte after write control loads address pointer
// - stop after data starts busy; no acks
// - protected write acked but memory unchanged
// - full write time even when protected
// - up to sixteen page bytes, committed when write time ends
// - data bytes bump only pointer low nibble
// - over sixteen bytes wrap and overwrite buffer
// - protect pin high blocks upper half writes
// - control byte not acked while busy
// - read control byte has low bit high
// - current read returns byte after last access
// - master nack then stop ends read
// - repeated start keeps pointer, drops write data
// - after read pointer is next location
// - master ack asks for next sequential byte
// - read pointer wraps from top to zero
// - respond only to code and matching selects
// - release data line after master nack
package see_pkg;
	// device code value is arbitrary
	localparam logic [3:0] DEV_CODE = 4'h6;
	localparam logic [7:0] PROTECT_BASE = 8'h80;
	localparam int PAGE_SIZE = 16;
	localparam logic [3:0] CNT_BYTE = 4'h7;
	localparam logic [3:0] CNT_ACK = 4'h8;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [7:0] PTR_ONE = 8'h01;
	localparam int CLOCK_PERIOD_NS = 5;
	localparam int WRITE_TIME_NS = 1000000;
	localparam int WCNT_W = 24;
	localparam logic [WCNT_W-1:0] WCNT_LAST = 24'h000001;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CTRL = 3'h1,
		ST_ADDR = 3'h3,
		ST_WDATA = 3'h2,
		ST_READ = 3'h6,
		ST_IGNORE = 3'h7
	} see_state_type;
endpackage

//--- verilog/see_eeprom_slave.sv
`timescale 1ns/1ps
module see_eeprom_slave #(
	parameter int WRITE_CYCLES =
		(see_pkg::WRITE_TIME_NS + see_pkg::CLOCK_PERIOD_NS - 1) / see_pkg::CLOCK_PERIOD_NS
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic write_protect,
	input wire logic select_pin_0,
	input wire logic select_pin_1,
	input wire logic select_pin_2
);
	import see_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// link domain: each rising scl edge outside link reset captures one data bit and flips a toggle
	logic lrst1_q, lrst2_q, lbit_q, ltog_q;

	always_ff @(posedge scl) begin
		lrst1_q <= reset;
		lrst2_q <= lrst1_q;
	end

	always_ff @(posedge scl) begin
		if (lrst2_q) begin
			lbit_q <= 1'b0;
			ltog_q <= 1'b0;
		end else begin
			lbit_q <= sda_in;
			ltog_q <= ~ltog_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// system domain synchronisers
	logic scl1_q, scl2_q, scl3_q, sda1_q, sda2_q, sda3_q;
	logic tog1_q, tog2_q, tog3_q, wp1_q, wp_q;
	logic [2:0] sel1_q, sel_q;

	always_ff @(posedge clock) begin
		if (reset) begin
			{scl1_q, scl2_q, scl3_q, sda1_q, sda2_q, sda3_q} <= '1;
			{tog1_q, tog2_q, tog3_q, wp1_q, wp_q} <= '0;
			sel1_q <= '0;
			sel_q <= '0;
		end else begin
			{scl1_q, scl2_q, scl3_q} <= {scl, scl1_q, scl2_q};
			{sda1_q, sda2_q, sda3_q} <= {sda_in, sda1_q, sda2_q};
			{tog1_q, tog2_q, tog3_q} <= {ltog_q, tog1_q, tog2_q};
			{wp1_q, wp_q} <= {write_protect, wp1_q};
			sel1_q <= {select_pin_2, select_pin_1, select_pin_0};
			sel_q <= sel1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state
	see_state_type state_q, state_d;
	logic [3:0] cnt_q, cnt_d, base_q, base_d;
	logic [7:0] sh_q, sh_d, ptr_q, ptr_d, tx_q;
	logic ack_q, ack_d, pend_q, pend_d, busy_q, oe_n_q, oe_n_d;
	logic [WCNT_W-1:0] wcnt_q;
	logic [PAGE_SIZE-1:0] valid_q, wr_mask;
	logic [7:0] pbuf [PAGE_SIZE];
	logic [7:0] mem [256];

	// lbit_q is stable for several clocks before its toggle shows up here
	wire rx_w = tog2_q ^ tog3_q;
	wire start_w = scl2_q && scl3_q && sda3_q && !sda2_q;
	wire stop_w = scl2_q && scl3_q && !sda3_q && sda2_q;
	wire fall_w = scl3_q && !scl2_q;
	wire [7:0] byte_w = {sh_q[6:0], lbit_q};
	wire byte_end = rx_w && cnt_q == CNT_BYTE;
	wire ack_end = rx_w && cnt_q == CNT_ACK;
	wire match_w = byte_w[7:4] == DEV_CODE && byte_w[3:1] == sel_q && !busy_q;
	wire commit_w = busy_q && wcnt_q == WCNT_LAST;
	wire wbuf_en = state_q == ST_WDATA && byte_end;
	wire enter_rd = state_q == ST_CTRL && ack_q && sh_q[0];
	wire load_w = ack_end && (enter_rd || (state_q == ST_READ && !lbit_q));
	wire tx_bit = tx_q[3'(CNT_BYTE - cnt_q)];

	// protected bytes are simply dropped from the commit
	for (genvar i = 0; i < PAGE_SIZE; i++) begin : g_mask
		assign wr_mask[i] = valid_q[i] && !(wp_q && {base_q, 4'(i)} >= PROTECT_BASE);
	end

	////////////////////////////////////////////////////////////////////////
	// byte sequencing
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		ack_d = ack_q;
		ptr_d = ptr_q;
		base_d = base_q;
		pend_d = pend_q;
		if (rx_w && cnt_q != CNT_ACK) begin
			sh_d = byte_w;
			cnt_d = cnt_q + CNT_ONE;
		end
		if (byte_end) begin
			case (state_q)
				ST_CTRL: ack_d = match_w;
				ST_ADDR: begin
					ptr_d = byte_w;
					base_d = byte_w[7:4];
					ack_d = 1'b1;
				end
				ST_WDATA: begin
					ptr_d = {ptr_q[7:4], ptr_q[3:0] + CNT_ONE};
					pend_d = 1'b1;
					ack_d = 1'b1;
				end
				default: ack_d = 1'b0;
			endcase
		end
		if (ack_end) begin
			cnt_d = '0;
			case (state_q)
				ST_CTRL: state_d = !ack_q ? ST_IGNORE : (sh_q[0] ? ST_READ : ST_ADDR);
				ST_ADDR: state_d = ST_WDATA;
				ST_READ: state_d = lbit_q ? ST_IGNORE : ST_READ;
				default: state_d = state_q;
			endcase
		end
		if (load_w)
			ptr_d = ptr_q + PTR_ONE;
		if (start_w) begin
			// a repeated start abandons buffered data but keeps the pointer
			state_d = ST_CTRL;
			cnt_d = '0;
			ack_d = 1'b0;
			pend_d = 1'b0;
		end
		if (stop_w) begin
			state_d = ST_IDLE;
			cnt_d = '0;
			ack_d = 1'b0;
			pend_d = 1'b0;
		end
	end

	// data changes only after scl falls, so the master samples it stable
	always_comb begin
		oe_n_d = oe_n_q;
		if (fall_w) begin
			if (state_q == ST_READ && cnt_q != CNT_ACK)
				oe_n_d = tx_bit;
			else
				oe_n_d = !(cnt_q == CNT_ACK && ack_q);
		end
		if (start_w || stop_w)
			oe_n_d = 1'b1;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			sh_q <= '0;
			ack_q <= 1'b0;
			ptr_q <= '0;
			base_q <= '0;
			pend_q <= 1'b0;
			oe_n_q <= 1'b1;
			sda_out <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			ack_q <= ack_d;
			ptr_q <= ptr_d;
			base_q <= base_d;
			pend_q <= pend_d;
			oe_n_q <= oe_n_d;
			sda_out <= 1'b0;
		end
	end

	assign sda_oe_n = oe_n_q;

	////////////////////////////////////////////////////////////////////////
	// page buffer, write cycle timer and array
	always_ff @(posedge clock) begin
		if (reset) begin
			busy_q <= 1'b0;
			wcnt_q <= '0;
		end else if (stop_w && pend_q && !busy_q) begin
			busy_q <= 1'b1;
			wcnt_q <= WCNT_W'(WRITE_CYCLES);
		end else if (busy_q) begin
			wcnt_q <= wcnt_q - WCNT_LAST;
			busy_q <= !commit_w;
		end
	end

	always_ff @(posedge clock) begin
		if (reset)
			valid_q <= '0;
		else if (commit_w || (start_w && !busy_q && !stop_w && pend_q))
			valid_q <= '0;
		else if (wbuf_en)
			valid_q[ptr_q[3:0]] <= 1'b1;
	end

	always_ff @(posedge clock) begin
		if (wbuf_en)
			pbuf[ptr_q[3:0]] <= byte_w;
	end

	always_ff @(posedge clock) begin
		for (int i = 0; i < PAGE_SIZE; i++) begin
			if (commit_w && wr_mask[i])
				mem[{base_q, 4'(i)}] <= pbuf[i];
		end
	end

	always_ff @(posedge clock) begin
		if (reset)
			tx_q <= '0;
		else if (load_w)
			tx_q <= mem[ptr_q];
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	sequence s_ctrl_byte;
		state_q == ST_CTRL && byte_end;
	endsequence
	sequence s_read_ack;
		state_q == ST_READ && ack_end && !lbit_q;
	endsequence
	sequence s_read_nack;
		state_q == ST_READ && ack_end && lbit_q;
	endsequence

	a_ctrl_busy_nak: assert property (s_ctrl_byte ##0 busy_q |=> !ack_q)
		else $error("control byte acked while busy");
	a_ctrl_match: assert property (s_ctrl_byte ##0 match_w |=> ack_q)
		else $error("matching control byte not acked");
	a_ctrl_select: assert property (s_ctrl_byte ##0 (byte_w[3:1] != sel_q) |=> !ack_q)
		else $error("foreign select bits acked");
	a_addr_load: assert property ((state_q == ST_ADDR && byte_end) |=>
		(ptr_q == $past(byte_w) && ack_q))
		else $error("word address not loaded");
	a_page_wrap: assert property (wbuf_en |=> (ptr_q[7:4] == $past(ptr_q[7:4]) &&
		ptr_q[3:0] == 4'($past(ptr_q[3:0]) + CNT_ONE)))
		else $error("page pointer step wrong");
	a_stop_busy: assert property ((stop_w && pend_q && !busy_q) |=>
		(busy_q && wcnt_q == WCNT_W'(WRITE_CYCLES)))
		else $error("write cycle not started at stop");
	a_busy_hold: assert property ((busy_q && !commit_w) |=> busy_q)
		else $error("busy dropped early");
	a_busy_end: assert property (commit_w |=> !busy_q)
		else $error("busy held past count");
	a_protect_mask: assert property ((commit_w && wp_q && base_q[3]) |-> wr_mask == '0)
		else $error("protected half written");
	a_read_next: assert property (s_read_ack |=> ptr_q == $past(ptr_q) + PTR_ONE)
		else $error("read pointer not advanced");
	a_nack_release: assert property (s_read_nack |=>
		state_q == ST_IGNORE ##0 sda_oe_n[*4])
		else $error("line not released after nack");
	a_repstart_keep: assert property ((start_w && !stop_w && !busy_q) |=>
		(!pend_q && ptr_q == $past(ptr_q)))
		else $error("repeated start disturbed pointer");

	// answers on the line: ack slots and releases
	a_ack_drive: assert property ((fall_w && state_q != ST_READ && cnt_q == CNT_ACK &&
		ack_q && !start_w && !stop_w) |=> !sda_oe_n)
		else $error("ack not driven");
	a_busy_quiet: assert property ((busy_q && fall_w && state_q == ST_CTRL &&
		cnt_q == CNT_ACK) |=> sda_oe_n)
		else $error("ack driven while busy");
	a_read_release: assert property ((fall_w && state_q == ST_READ &&
		cnt_q == CNT_ACK) |=> sda_oe_n)
		else $error("line held in master ack slot");
	a_stop_idle: assert property (stop_w |=> (state_q == ST_IDLE && sda_oe_n))
		else $error("stop did not end transfer");
	a_quiet_release: assert property ((state_q == ST_IDLE || state_q == ST_IGNORE) |->
		sda_oe_n)
		else $error("line driven while unaddressed");
	a_cnt_range: assert property (cnt_q <= CNT_ACK)
		else $error("bit counter past ack slot");
	a_wdata_ack: assert property (wbuf_en |=> ack_q)
		else $error("data byte not acked");
	a_base_track: assert property ((state_q == ST_ADDR && byte_end) |=>
		base_q == $past(byte_w[7:4]))
		else $error("page base not taken from address");

	// every byte that survives the mask must reach the array at commit
	for (genvar i = 0; i < PAGE_SIZE; i++) begin : g_commit
		a_page_commit: assert property ((commit_w && wr_mask[i]) |=>
			mem[{base_q, 4'(i)}] == $past(pbuf[i]))
			else $error("page byte not committed");
	end

endmodule // see_eeprom_slave

//--- testbench/see_master_model.sv
`timescale 1ns/1ps
module see_master_model (
	output logic scl,
	output logic sda_m,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// sda moves only while scl is low; the 30 ns low phase outlasts the answer latency
	task automatic bit_io(input logic v, output logic s);
		#10 sda_m = v;
		#20 scl = 1'b1;
		s = sda;
		#30 scl = 1'b0;
	endtask
	task automatic start();
		#10 sda_m = 1'b1;
		#20 scl = 1'b1;
		#30 sda_m = 1'b0;
		#30 scl = 1'b0;
	endtask
	task automatic stop();
		#10 sda_m = 1'b0;
		#20 scl = 1'b1;
		#30 sda_m = 1'b1;
		#30;
	endtask
	task automatic send(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	task automatic recv(input logic more, output logic [7:0] b, output logic rel);
		for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
		bit_io(~more, rel);
	endtask
	// scl edges with sda high, so the link side sees reset
	task automatic pulse();
		#30 scl = 1'b0;
		#30 scl = 1'b1;
	endtask
endmodule // see_master_model

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
	import see_pkg::*;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic wp = 1'b0;
	logic [2:0] sel = 3'h5;
	logic scl, sda_m, sda_out, sda_oe_n, a;
	wire sda = sda_m & (sda_oe_n | sda_out);
	logic [7:0] mem [256];
	logic [255:0] ok = '0;
	logic [7:0] ptr, d, ad;
	logic [31:0] seed = 32'h000061E2;
	int failures = 0;
	int n_tests = 0;
	always #2.5 clock = ~clock;
	see_eeprom_slave #(.WRITE_CYCLES(400)) i_dut (.clock(clock), .reset(reset), .scl(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .write_protect(wp),
		.select_pin_0(sel[0]), .select_pin_1(sel[1]), .select_pin_2(sel[2]));
	see_master_model i_mst (.scl(scl), .sda_m(sda_m), .sda(sda));
	//////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic logic [7:0] ctl(input logic r);
		return {DEV_CODE, sel, r};
	endfunction
	task check(input string what, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	task test_done();
		if (failures == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// a poll that is never answered would hang the run, so it is bounded
	task poll(output int n);
		n = 0;
		a = 1'b0;
		while (!a && n < 50) begin
			i_mst.start();
			i_mst.send(ctl(1'b0), a);
			n++;
		end
		i_mst.stop();
		if (!a) begin
			failures++;
			test_done();
		end
	endtask
	task wr(input logic [7:0] ad, input int n);
		int k;
		logic [7:0] w;
		i_mst.start();
		i_mst.send(ctl(1'b0), a);
		check("ctl ack", 8'h01, 8'(a));
		i_mst.send(ad, a);
		check("addr ack", 8'h01, 8'(a));
		for (int j = 0; j < n; j++) begin
			d = rnd();
			w = {ad[7:4], ad[3:0] + j[3:0]};
			i_mst.send(d, a);
			check("data ack", 8'h01, 8'(a));
			if (!(wp && ad[7])) begin
				mem[w] = d;
				ok[w] = 1'b1;
			end
		end
		i_mst.stop();
		poll(k);
		check("refused polls", 8'h01, 8'(k > 1));
	endtask
	task cur(input int n);
		i_mst.start();
		i_mst.send(ctl(1'b1), a);
		check("read ack", 8'h01, 8'(a));
		for (int j = 0; j < n; j++) begin
			i_mst.recv(j < n - 1, d, a);
			if (ok[ptr]) check("read data", mem[ptr], d);
			ptr++;
		end
		check("released", 8'h01, 8'(a));
		i_mst.stop();
	endtask
	task rd(input logic [7:0] ad, input int n);
		i_mst.start();
		i_mst.send(ctl(1'b0), a);
		i_mst.send(ad, a);
		ptr = ad;
		cur(n);
	endtask
	initial begin
		fork
			repeat (10) @(posedge clock);
			repeat (2) i_mst.pulse();
		join
		@(posedge clock);
		#1 reset = 1'b0;
		// the link side leaves reset only after two more scl rises
		repeat (2) i_mst.pulse();
		i_mst.start();
		i_mst.send({DEV_CODE, ~sel, 1'b0}, a);
		check("foreign sel", 8'h00, 8'(a));
		i_mst.start();
		i_mst.send({~DEV_CODE, sel, 1'b0}, a);
		check("foreign code", 8'h00, 8'(a));
		i_mst.stop();
		wr(8'hFF, 1);
		wr(8'h00, 1);
		rd(8'hFF, 2);
		wr(8'h3A, 20);
		rd(8'h30, 16);
		for (int t = 0; t < 8; t++) begin
			if (!t[0]) ad = {t[1], 7'(rnd())};
			@(posedge clock);
			#1 wp = t[0];
			wr(ad, 1 + rnd() % (16 - ad[3:0]));
			rd({ad[7:4], 4'h0}, 16);
			cur(1);
		end
		test_done();
	end
	initial begin
		#400000;
		failures++;
		test_done();
	end
endmodule // tb
